// >>> shared/cts_defines.vh
`ifndef CTS_DEFINES_VH
`define CTS_DEFINES_VH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define CTS_OFF_CTRL      12'h000
`define CTS_OFF_IN_LVL    12'h004
`define CTS_OFF_VN_LVL    12'h008
`define CTS_OFF_CT_DLY    12'h00c
`define CTS_OFF_TICK      12'h010
`define CTS_OFF_STATUS    12'h014
`define CTS_OFF_IRQ_STAT  12'h018
`define CTS_OFF_IRQ_MASK  12'h01c
`define CTS_OFF_LIVE      12'h020
// ----------------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------------
`define CTS_CTRL_CT_EN    0
`define CTS_CTRL_DIFF_RST 1
`define CTS_CTRL_DUAL     2
`define CTS_CTRL_DUAL_AUX 3
`define CTS_CTRL_W        4
// ----------------------------------------------------------------------
// interrupt / status bit positions
// ----------------------------------------------------------------------
`define CTS_EV_CT_FAIL    0
`define CTS_EV_TRIP_FAIL  1
`define CTS_EV_BRK_DISAG  2
`define CTS_EV_W          3
// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define CTS_CTRL_RST      4'h0
`define CTS_LVL_RST       16'hffff
`define CTS_CT_DLY_RST    32'h00001388
`define CTS_TICK_RST      32'h00030d40
`define CTS_CLK_HZ        200000000
`define CTS_TICK_NS_MS    1000000
`define CTS_DROP_OFF_MS   400
`define CTS_PICK_UP_MS    50
`endif

// >>> design/cts_delay_timer.v
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// generic delay timer: pick-up on a rising condition, drop-off on fall
// ----------------------------------------------------------------------
module cts_delay_timer #(
    parameter W = 32
) (
    input  wire         sys_clk_i, // system clock
    input  wire         reset_i,   // async reset, active high
    input  wire         tick_i,    // one-cycle time base tick
    input  wire         cond_i,    // timed condition
    input  wire [W-1:0] limit_i,   // ticks to wait
    input  wire         pickup_i,  // 1: delay on rise, 0: delay on fall
    output reg          out_o      // delayed output
);
    reg [W-1:0] cnt_q; // elapsed ticks

    // counts ticks while the condition differs from the output
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_q <= {W{1'b0}};
            out_o <= 1'b0;
        end else if (pickup_i ? !cond_i : cond_i) begin
            // immediate side: restart the count from zero
            cnt_q <= {W{1'b0}};
            out_o <= cond_i;
        end else if (out_o != cond_i) begin
            if (cnt_q >= limit_i) begin
                out_o <= cond_i;
                cnt_q <= {W{1'b0}};
            end else if (tick_i) begin
                cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
            end
        end else begin
            cnt_q <= {W{1'b0}};
        end
    end
endmodule // cts_delay_timer

// >>> design/cts_supervision.v
// Contract
// - residual current without residual voltage means failure
// - residual voltage above inhibit blocks detection
// - current counts only above level setting
// - disabled function gives no failure, no blocking
// - failure raised after operating delay persists
// - failure blocks derived-quantity protection elements
// - optional restraint of differential protection
// - drop-off timer holds 400 ms after input
// - asserted timer opens alarm relay, resets alarms
// - fail indication is inverted drop-off output
// - 50 ms pick-up before LED and alarm
// - dual scheme alarms only with both inputs low
// - breaker status from both auxiliary contacts
// - normally-open aux true when breaker closed
`timescale 1ns/100ps
`include "cts_defines.vh"
module cts_supervision #(
    parameter LW = 16 // magnitude width
) (
    input  wire          sys_clk_i,   // system clock, 200 MHz
    input  wire          reset_i,     // async reset, active high
    // ahb-lite slave
    input  wire          hsel_i,
    input  wire [11:0]   haddr_i,
    input  wire [1:0]    htrans_i,
    input  wire          hwrite_i,
    input  wire [2:0]    hsize_i,
    input  wire [31:0]   hwdata_i,
    input  wire          hready_i,
    output reg  [31:0]   hrdata_o,
    output reg           hreadyout_o,
    output reg           hresp_o,
    // measured quantities
    input  wire [LW-1:0] resid_current_i,  // derived residual current
    input  wire [LW-1:0] resid_voltage_i,  // derived residual voltage
    // opto-inputs
    input  wire          trip_circuit_monitor_a_i, // supervision opto 1
    input  wire          trip_circuit_monitor_b_i, // supervision opto 2
    input  wire          breaker_normally_open_aux_i,
    input  wire          breaker_normally_closed_aux_i,
    // outputs
    output reg           ct_fail_o,       // current-input failure
    output reg           derived_block_o, // block derived elements
    output reg           diff_restrain_o, // restrain differential
    output reg           alarm_relay_closed_o, // nc relay contact closed
    output reg           trip_fail_led_o, // latching led
    output reg           trip_fail_alarm_o, // user alarm signal
    output reg           breaker_closed_o,  // breaker status
    output reg           irq_o            // level interrupt
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    reg [`CTS_CTRL_W-1:0] ctrl_q;    // control bits
    reg [LW-1:0]          in_lvl_q;  // residual current level
    reg [LW-1:0]          vn_lvl_q;  // residual_voltage_inhibit_level
    reg [31:0]            ct_dly_q;  // operating delay, ticks
    reg [31:0]            tick_q;    // clocks per tick
    reg [`CTS_EV_W-1:0]   ist_q;     // sticky events
    reg [`CTS_EV_W-1:0]   imask_q;   // interrupt mask
    reg [31:0]            div_q;     // tick divider
    reg                   tick_q1;   // one-cycle tick
    reg                   led_latch_q; // latched led state
    reg [`CTS_EV_W-1:0]   ev_prev_q; // previous event levels
    // bus address phase capture
    reg                   wr_q;      // pending write
    reg                   rd_q;      // pending read
    reg [11:0]            addr_q;    // captured address

    // fixed delays as tick counts, one tick per millisecond by default
    localparam [31:0] DROP_TICKS = `CTS_DROP_OFF_MS;
    localparam [31:0] PICK_TICKS = `CTS_PICK_UP_MS;

    wire ct_en     = ctrl_q[`CTS_CTRL_CT_EN];
    wire dual_mode = ctrl_q[`CTS_CTRL_DUAL];
    wire dual_aux  = ctrl_q[`CTS_CTRL_DUAL_AUX];

    // ------------------------------------------------------------------
    // time base
    // ------------------------------------------------------------------
    // tick period is software-set so delays scale with one register
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_q   <= 32'h00000000;
            tick_q1 <= 1'b0;
        end else if (div_q + 32'h00000001 >= tick_q) begin
            div_q   <= 32'h00000000;
            tick_q1 <= 1'b1;
        end else begin
            div_q   <= div_q + 32'h00000001;
            tick_q1 <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // current-input supervision
    // ------------------------------------------------------------------
    wire in_present = resid_current_i > in_lvl_q;
    wire vn_present = resid_voltage_i > vn_lvl_q;
    // raw condition gated by enable so nothing arms while disabled
    wire ct_cond    = ct_en && in_present && !vn_present;
    wire ct_timed;

    cts_delay_timer #(.W(32)) u_ct_dly (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .tick_i    (tick_q1),
        .cond_i    (ct_cond),
        .limit_i   (ct_dly_q),
        .pickup_i  (1'b1),
        .out_o     (ct_timed)
    );

    // ------------------------------------------------------------------
    // trip circuit supervision
    // ------------------------------------------------------------------
    // dual scheme: healthy while either opto sees current
    wire tcm_live = dual_mode ?
        (trip_circuit_monitor_a_i | trip_circuit_monitor_b_i) :
        trip_circuit_monitor_a_i;
    wire drop_off_delay_timer;
    wire fail_delayed;

    cts_delay_timer #(.W(32)) u_drop (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .tick_i    (tick_q1),
        .cond_i    (tcm_live),
        .limit_i   (DROP_TICKS),
        .pickup_i  (1'b0),
        .out_o     (drop_off_delay_timer)
    );

    // inverted drop-off output is the fail indication
    cts_delay_timer #(.W(32)) u_pick (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .tick_i    (tick_q1),
        .cond_i    (!drop_off_delay_timer),
        .limit_i   (PICK_TICKS),
        .pickup_i  (1'b1),
        .out_o     (fail_delayed)
    );

    // ------------------------------------------------------------------
    // breaker status
    // ------------------------------------------------------------------
    // with both contacts the status only moves when they agree (complementary levels)
    wire aux_agree = breaker_normally_open_aux_i ^
                     breaker_normally_closed_aux_i;
    wire brk_disag = dual_aux && !aux_agree;

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // all outputs registered; led latches until disabled by timer reset
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ct_fail_o            <= 1'b0;
            derived_block_o      <= 1'b0;
            diff_restrain_o      <= 1'b0;
            alarm_relay_closed_o <= 1'b1;
            trip_fail_led_o      <= 1'b0;
            trip_fail_alarm_o    <= 1'b0;
            breaker_closed_o     <= 1'b0;
            led_latch_q          <= 1'b0;
        end else begin
            ct_fail_o       <= ct_en && ct_timed;
            derived_block_o <= ct_en && ct_timed;
            diff_restrain_o <= ct_en && ct_timed &&
                               ctrl_q[`CTS_CTRL_DIFF_RST];
            // nc relay open while the timer holds
            alarm_relay_closed_o <= !drop_off_delay_timer;
            if (drop_off_delay_timer) begin
                led_latch_q       <= 1'b0;
                trip_fail_alarm_o <= 1'b0;
            end else begin
                led_latch_q       <= led_latch_q | fail_delayed;
                trip_fail_alarm_o <= fail_delayed;
            end
            trip_fail_led_o <= !drop_off_delay_timer &&
                               (led_latch_q | fail_delayed);
            if (!dual_aux)
                breaker_closed_o <= breaker_normally_open_aux_i;
            else if (aux_agree)
                breaker_closed_o <= breaker_normally_open_aux_i;
        end
    end

    // ------------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------------
    wire [`CTS_EV_W-1:0] ev_lvl = {brk_disag, fail_delayed, ct_timed};
    wire [`CTS_EV_W-1:0] ev_set = ev_lvl & ~ev_prev_q;
    wire [`CTS_EV_W-1:0] ist_clr = (wr_q &&
        addr_q == `CTS_OFF_IRQ_STAT) ? hwdata_i[`CTS_EV_W-1:0] :
        {`CTS_EV_W{1'b0}};

    // rising edge sets; a set in the clearing cycle wins
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ev_prev_q <= {`CTS_EV_W{1'b0}};
            ist_q     <= {`CTS_EV_W{1'b0}};
            irq_o     <= 1'b0;
        end else begin
            ev_prev_q <= ev_lvl;
            ist_q     <= (ist_q & ~ist_clr) | ev_set;
            irq_o     <= |(ist_q & imask_q);
        end
    end

    // ------------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------------
    wire take = hsel_i && hready_i && htrans_i[1];

    // address phase capture, zero wait states
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            wr_q        <= 1'b0;
            rd_q        <= 1'b0;
            addr_q      <= 12'h000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            wr_q        <= take && hwrite_i;
            rd_q        <= take && !hwrite_i;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            if (take)
                addr_q <= {haddr_i[11:2], 2'b00};
        end
    end

    // register writes in the data phase
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ctrl_q   <= `CTS_CTRL_RST;
            in_lvl_q <= `CTS_LVL_RST;
            vn_lvl_q <= `CTS_LVL_RST;
            ct_dly_q <= `CTS_CT_DLY_RST;
            tick_q   <= `CTS_TICK_RST;
            imask_q  <= {`CTS_EV_W{1'b0}};
        end else if (wr_q) begin
            case (addr_q)
                `CTS_OFF_CTRL:     ctrl_q   <= hwdata_i[`CTS_CTRL_W-1:0];
                `CTS_OFF_IN_LVL:   in_lvl_q <= hwdata_i[LW-1:0];
                `CTS_OFF_VN_LVL:   vn_lvl_q <= hwdata_i[LW-1:0];
                `CTS_OFF_CT_DLY:   ct_dly_q <= hwdata_i;
                `CTS_OFF_TICK:     tick_q   <= hwdata_i;
                `CTS_OFF_IRQ_MASK: imask_q  <= hwdata_i[`CTS_EV_W-1:0];
                default: ;        // unmapped: ignored
            endcase
        end
    end

    // read data registered one cycle after the address phase
    // unmapped offsets read as zero whatever the level width
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            hrdata_o <= 32'h00000000;
        end else if (take && !hwrite_i) begin
            case ({haddr_i[11:2], 2'b00})
                `CTS_OFF_CTRL:     hrdata_o <= {28'h0000000, ctrl_q};
                `CTS_OFF_IN_LVL:   hrdata_o <= {{(32-LW){1'b0}}, in_lvl_q};
                `CTS_OFF_VN_LVL:   hrdata_o <= {{(32-LW){1'b0}}, vn_lvl_q};
                `CTS_OFF_CT_DLY:   hrdata_o <= ct_dly_q;
                `CTS_OFF_TICK:     hrdata_o <= tick_q;
                `CTS_OFF_STATUS:   hrdata_o <= {24'h000000,
                    breaker_closed_o, trip_fail_led_o, trip_fail_alarm_o,
                    alarm_relay_closed_o, diff_restrain_o,
                    derived_block_o, drop_off_delay_timer, ct_fail_o};
                `CTS_OFF_IRQ_STAT: hrdata_o <= {29'h00000000, ist_q};
                `CTS_OFF_IRQ_MASK: hrdata_o <= {29'h00000000, imask_q};
                `CTS_OFF_LIVE:     hrdata_o <= {30'h00000000,
                    resid_voltage_i > vn_lvl_q, resid_current_i > in_lvl_q};
                default:           hrdata_o <= 32'h00000000;
            endcase
        end
    end
endmodule // cts_supervision

// >>> tb/cts_supervision_assertions.sv
`timescale 1ns/100ps
// -------
// checker on the supervision block's pins
// -------
module cts_supervision_checker #(
    parameter LW = 16
) (
    input wire          sys_clk_i,
    input wire          reset_i,
    input wire          hreadyout_o,
    input wire          hresp_o,
    input wire [LW-1:0] resid_current_i,
    input wire          trip_circuit_monitor_a_i,
    input wire          breaker_normally_open_aux_i,
    input wire          breaker_normally_closed_aux_i,
    input wire          ct_fail_o,
    input wire          derived_block_o,
    input wire          alarm_relay_closed_o,
    input wire          trip_fail_led_o,
    input wire          trip_fail_alarm_o,
    input wire          breaker_closed_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    reg [1:0] up_q; // edges since reset, saturating
    // $stable looks back into reset, so wait before trusting it
    always @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) up_q <= 2'h0;
        else if (up_q != 2'h3) up_q <= up_q + 2'h1;
    end
    a_bus_okay: assert property (hreadyout_o && !hresp_o)
        else $error("bus answer not zero wait okay");
    a_block_follows: assert property (
        $changed(ct_fail_o) |-> ##[0:2] (derived_block_o == ct_fail_o))
        else $error("block does not follow ct failure");
    a_fail_cause: assert property (
        $rose(ct_fail_o) |-> $past(resid_current_i, 2) != 0
            && $past(resid_current_i, 8) != 0)
        else $error("ct failure without residual current");
    a_relay_opens: assert property (
        $rose(trip_circuit_monitor_a_i) |-> ##[1:3] !alarm_relay_closed_o)
        else $error("relay not opened by energised opto");
    a_alarm_clears: assert property (
        $fell(alarm_relay_closed_o) |->
            ##[0:2] (!trip_fail_alarm_o && !trip_fail_led_o))
        else $error("alarm not reset while timer asserted");
    a_alarm_pickup: assert property (
        $rose(trip_fail_alarm_o) |-> $past(alarm_relay_closed_o, 2)
            && $past(alarm_relay_closed_o, 8))
        else $error("alarm raised without pick-up delay");
    a_led_with_alarm: assert property (
        $rose(trip_fail_alarm_o) |-> ##[0:1] trip_fail_led_o)
        else $error("led not lit with alarm");
    a_breaker_state: assert property (
        (up_q == 2'h3 && (breaker_normally_open_aux_i
            ^ breaker_normally_closed_aux_i)
            && $stable(breaker_normally_open_aux_i)
            && $stable(breaker_normally_closed_aux_i))[*3]
        |-> breaker_closed_o == breaker_normally_open_aux_i)
        else $error("breaker state differs from aux pair");
    c_ct_fail: cover property ($rose(ct_fail_o));
    c_trip_alarm: cover property ($rose(trip_fail_alarm_o));
    c_breaker_open: cover property ($fell(breaker_closed_o));
endmodule // cts_supervision_checker
bind cts_supervision cts_supervision_checker #(.LW(LW)) u_chk (
    .sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .resid_current_i(resid_current_i),
    .trip_circuit_monitor_a_i(trip_circuit_monitor_a_i),
    .breaker_normally_open_aux_i(breaker_normally_open_aux_i),
    .breaker_normally_closed_aux_i(breaker_normally_closed_aux_i),
    .ct_fail_o(ct_fail_o), .derived_block_o(derived_block_o),
    .alarm_relay_closed_o(alarm_relay_closed_o),
    .trip_fail_led_o(trip_fail_led_o),
    .trip_fail_alarm_o(trip_fail_alarm_o),
    .breaker_closed_o(breaker_closed_o));

// >>> tb/cts_plant_model.sv
`timescale 1ns/100ps
// -------
// plant: current inputs, trip circuit optos, breaker contacts
// -------
module cts_plant_model (
    input  wire        sys_clk_i,
    output reg  [15:0] resid_current_o,
    output reg  [15:0] resid_voltage_o,
    output reg         opto_a_o,
    output reg         opto_b_o,
    output reg         aux_no_o,
    output reg         aux_nc_o
);
    // healthy start: trip circuit energised, breaker closed
    initial begin
        resid_current_o = 16'h0;
        resid_voltage_o = 16'h0;
        opto_a_o = 1'h1;
        opto_b_o = 1'h0;
        aux_no_o = 1'h1;
        aux_nc_o = 1'h0;
    end
    // every change lands just after an edge
    task set_ct(input [15:0] c, input [15:0] v);
        @(posedge sys_clk_i);
        resid_current_o <= c;
        resid_voltage_o <= v;
    endtask
    task set_opto(input a, input b);
        @(posedge sys_clk_i);
        opto_a_o <= a;
        opto_b_o <= b;
    endtask
    // a pair that is not complementary models a contact fault
    task set_aux(input no, input nc);
        @(posedge sys_clk_i);
        aux_no_o <= no;
        aux_nc_o <= nc;
    endtask
endmodule // cts_plant_model

// >>> tb/cts_supervision_tb.sv
`timescale 1ns/100ps
`include "cts_defines.vh"
module cts_supervision_tb;
    reg         clk, rst, hsel, hwrite;
    reg  [11:0] haddr;
    reg  [1:0]  htrans;
    reg  [2:0]  hsize;
    reg  [31:0] hwdata, rd;
    wire [31:0] hrdata;
    wire [15:0] cur, volt;
    wire        hready, hresp, opa, opb, ano, anc;
    wire        ct_fail, blk, rstr, relay, led, alarm, brk, irq;
    integer     mismatches = 0, comparisons = 0, cyc = 0;
    cts_supervision #(.LW(16)) u_dut (.sys_clk_i(clk), .reset_i(rst),
        .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .resid_current_i(cur), .resid_voltage_i(volt),
        .trip_circuit_monitor_a_i(opa), .trip_circuit_monitor_b_i(opb),
        .breaker_normally_open_aux_i(ano),
        .breaker_normally_closed_aux_i(anc), .ct_fail_o(ct_fail),
        .derived_block_o(blk), .diff_restrain_o(rstr),
        .alarm_relay_closed_o(relay), .trip_fail_led_o(led),
        .trip_fail_alarm_o(alarm), .breaker_closed_o(brk), .irq_o(irq));
    cts_plant_model u_plant (.sys_clk_i(clk), .resid_current_o(cur),
        .resid_voltage_o(volt), .opto_a_o(opa), .opto_b_o(opb),
        .aux_no_o(ano), .aux_nc_o(anc));
    // -------
    // helpers
    // -------
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    task complete_run;
        if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // a hang costs a mismatch and ends the run
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            complete_run;
        end
    end
    task chkw(input [31:0] g, input [31:0] e);
        comparisons = comparisons + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: word %h not %h", $time, g, e);
        end
    endtask
    task chkb(input g, input e);
        comparisons = comparisons + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: bit %b not %b", $time, g, e);
        end
    endtask
    // single word transfer; read data taken at the data phase edge
    task xfer(input w, input [11:0] a, input [31:0] d);
        @(posedge clk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'h1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'h1) @(posedge clk);
        rd = hrdata;
    endtask
    task wr(input [11:0] a, input [31:0] d);
        xfer(1'h1, a, d);
    endtask
    task rchk(input [11:0] a, input [31:0] e);
        xfer(1'h0, a, 32'h0);
        chkw(rd, e);
    endtask
    task waitc(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // -------
    // scenarios, tick of 2 clocks throughout
    // -------
    task test_regs;
        rchk(`CTS_OFF_CTRL, 32'h0);
        rchk(`CTS_OFF_IN_LVL, 32'hffff);
        rchk(`CTS_OFF_CT_DLY, 32'h1388);
        rchk(`CTS_OFF_TICK, 32'h30d40);
        wr(`CTS_OFF_TICK, 32'h2);
        rchk(`CTS_OFF_TICK, 32'h2);
        rchk(12'h040, 32'h0);
        chkb(hresp, 1'h0);
    endtask
    task test_ct;
        wr(`CTS_OFF_IN_LVL, 32'h64);
        wr(`CTS_OFF_VN_LVL, 32'h30);
        wr(`CTS_OFF_CT_DLY, 32'ha);
        wr(`CTS_OFF_CTRL, 32'h3);
        u_plant.set_ct(16'h64, 16'ha);
        waitc(40);
        chkb(ct_fail, 1'h0);
        u_plant.set_ct(16'hc8, 16'h31);
        waitc(40);
        chkb(ct_fail, 1'h0);
        u_plant.set_ct(16'hc8, 16'ha);
        waitc(14);
        u_plant.set_ct(16'h0, 16'ha);
        u_plant.set_ct(16'hc8, 16'ha);
        waitc(14);
        chkb(ct_fail, 1'h0);
        waitc(12);
        chkb(ct_fail, 1'h1);
        chkb(blk, 1'h1);
        chkb(rstr, 1'h1);
        chkb(irq, 1'h0);
        wr(`CTS_OFF_IRQ_MASK, 32'h1);
        waitc(3);
        chkb(irq, 1'h1);
        u_plant.set_ct(16'h0, 16'ha);
        rchk(`CTS_OFF_IRQ_STAT, 32'h1);
        wr(`CTS_OFF_IRQ_STAT, 32'h1);
        waitc(3);
        chkb(irq, 1'h0);
        wr(`CTS_OFF_CTRL, 32'h0);
        u_plant.set_ct(16'hc8, 16'ha);
        waitc(40);
        chkb(ct_fail, 1'h0);
        chkb(blk, 1'h0);
        u_plant.set_ct(16'h0, 16'h0);
    endtask
    task test_trip;
        chkb(relay, 1'h0);
        u_plant.set_opto(1'h0, 1'h0);
        waitc(790);
        chkb(relay, 1'h0);
        waitc(20);
        chkb(relay, 1'h1);
        chkb(alarm, 1'h0);
        waitc(100);
        chkb(alarm, 1'h1);
        chkb(led, 1'h1);
        rchk(`CTS_OFF_STATUS, 32'hf0);
        u_plant.set_opto(1'h1, 1'h0);
        waitc(4);
        chkb(relay, 1'h0);
        chkb(led, 1'h0);
        wr(`CTS_OFF_CTRL, 32'h4);
        u_plant.set_opto(1'h0, 1'h1);
        waitc(950);
        chkb(alarm, 1'h0);
        u_plant.set_opto(1'h0, 1'h0);
        waitc(910);
        chkb(alarm, 1'h1);
        u_plant.set_opto(1'h1, 1'h0);
    endtask
    task test_breaker;
        wr(`CTS_OFF_CTRL, 32'h8);
        u_plant.set_aux(1'h0, 1'h1);
        waitc(4);
        chkb(brk, 1'h0);
        u_plant.set_aux(1'h1, 1'h1);
        waitc(4);
        chkb(brk, 1'h0);
        xfer(1'h0, `CTS_OFF_IRQ_STAT, 32'h0);
        chkb(rd[`CTS_EV_BRK_DISAG], 1'h1);
        u_plant.set_aux(1'h1, 1'h0);
        waitc(4);
        chkb(brk, 1'h1);
    endtask
    initial begin
        rst = 1'h1;
        hsel = 1'h0;
        hwrite = 1'h0;
        haddr = 12'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        test_regs;
        test_ct;
        test_trip;
        test_breaker;
        complete_run;
    end
endmodule // cts_supervision_tb
